// *** rtl/fcfd_delay.sv ***
/*
  Head delay timer: counts a number of time units, then pulses expired.
  Assumes start is a one-cycle pulse from logic on the same clock.
*/
module fcfd_delay #(
  parameter int UNIT_CYCLES = 10000,
  parameter int WIDTH       = 8
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Control
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] units,
  // Status
  output logic                  busy,
  output logic                  expired
);
  initial begin
    if (UNIT_CYCLES < 1 || WIDTH < 1) begin
      $error("fcfd_delay: bad parameters");
    end
  end

  logic [WIDTH-1:0] cnt_q;
  logic [31:0]      pre_q;
  logic             run_q;
  logic             exp_q;

  // Unit prescaler and unit countdown
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      pre_q <= '0;
      run_q <= 1'b0;
    end else if (start) begin
      cnt_q <= units;
      pre_q <= '0;
      run_q <= 1'b1;
    end else if (run_q) begin
      if (cnt_q == '0) begin
        run_q <= 1'b0;
      end else if (pre_q == 32'(UNIT_CYCLES - 1)) begin
        pre_q <= '0;
        cnt_q <= cnt_q - 1'b1;
      end else begin
        pre_q <= pre_q + 32'h1;
      end
    end
  end

  // One-cycle expiry pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exp_q <= 1'b0;
    end else begin
      exp_q <= run_q && !start && (cnt_q == '0);
    end
  end

  assign busy    = run_q;
  assign expired = exp_q;
endmodule

// *** rtl/fcfd_pkg.sv ***
/*
  Constants for the command field decoder: register offsets, field positions,
  reset values, sector geometry and head timing counts.
  Assumes a 10 MHz APB clock; the decoder and the test bench import it.
*/
package fcfd_pkg;
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int HEAD_UNIT_NS  = 1000000;
  localparam int HEAD_UNIT_CYC = (HEAD_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [7:0] ADDR_CMD    = 8'h00;
  localparam logic [7:0] ADDR_PARAM  = 8'h04;
  localparam logic [7:0] ADDR_GAP    = 8'h08;
  localparam logic [7:0] ADDR_CFG    = 8'h0c;
  localparam logic [7:0] ADDR_TIMING = 8'h10;
  localparam logic [7:0] ADDR_CTRL   = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_LENGTH = 8'h1c;

  // Command register fields
  localparam int UNIT_SELECT_LO_BIT    = 0;
  localparam int UNIT_SELECT_HI_BIT    = 1;
  localparam int SIDE_SELECT_BIT       = 2;
  localparam int STEP_IN_BIT           = 3;
  localparam int CYLINDER_SPAN_BIT     = 4;
  localparam int DENSITY_MFM_BIT       = 5;
  localparam int VERIFY_COUNT_MODE_BIT = 6;
  localparam int VERIFY_CMD_BIT        = 7;
  localparam int HAS_CYLINDER_BIT      = 8;
  localparam int PERPENDICULAR_BIT     = 9;

  // Parameter register fields
  localparam int SIZE_CODE_LSB   = 0;
  localparam int SHORT_LEN_LSB   = 8;
  localparam int LAST_SECTOR_LSB = 16;
  localparam int FIRST_SECTOR_LSB = 24;

  // Gap register fields
  localparam int GAP3_LSB = 0;
  localparam int GAP2_LSB = 8;

  // Config register fields
  localparam int BUFFER_DISABLE_N_BIT = 0;
  localparam int IMPLIED_SEEK_BIT     = 1;
  localparam int LOCK_BIT             = 2;
  localparam int THRESHOLD_LSB        = 4;
  localparam int PRECOMP_LSB          = 8;
  localparam logic [15:0] CFG_RST     = 16'h0001;

  // Timing register fields
  localparam int SETTLE_LSB  = 0;
  localparam int RELEASE_LSB = 8;

  // Control register strobes
  localparam int CTRL_START_BIT    = 0;
  localparam int CTRL_SOFT_RST_BIT = 1;
  localparam int CTRL_EXEC_END_BIT = 2;

  // Sector geometry
  localparam logic [14:0] BASE_SECTOR_BYTES = 15'h0080;
  localparam logic [2:0]  MAX_SIZE_CODE     = 3'h7;
  localparam logic [7:0]  FIRST_SECTOR      = 8'h01;
  localparam logic [7:0]  GAP2_DEFAULT      = 8'h16;

  typedef enum logic [2:0] {
    PH_IDLE, PH_SEEK, PH_SETTLE, PH_EXEC, PH_RELEASE
  } phase_e;
endpackage

// *** rtl/floppy_command_field_decode.sv ***
/*
  Command field decoder: holds command and configuration fields written over
  APB, sequences seek, head settle, sector transfer and head release.
  Assumes the disk engine on the same clock supplies byte_tick, seek_done
  and identifier fields; no synchronisers are needed for them.
*/
module floppy_command_field_decode
  import fcfd_pkg::*;
#(
  parameter int HEAD_UNIT_CYCLES = HEAD_UNIT_CYC
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Disk engine
  input  wire logic        byte_tick,
  input  wire logic        seek_done,
  input  wire logic        id_valid,
  input  wire logic        id_side,
  // Drive and format controls
  output logic [3:0]       drive_sel,
  output logic             side_out,
  output logic             step_in,
  output logic             seek_req,
  output logic             head_load,
  output logic             mfm_mode,
  output logic             fifo_enable,
  output logic [3:0]       buffer_threshold,
  output logic [7:0]       precomp_start_cylinder,
  output logic [7:0]       gap3_len,
  output logic [7:0]       gap2_len,
  // Byte stream qualifiers
  output logic             host_byte_en,
  output logic             zero_fill,
  output logic             crc_byte_en,
  output logic [7:0]       sector_num,
  output logic             id_side_match,
  output logic             exec_active
);
  initial begin
    if (HEAD_UNIT_CYCLES < 1) begin
      $error("floppy_command_field_decode: HEAD_UNIT_CYCLES below 1");
    end
  end

  // Sector length for a size code
  function automatic logic [14:0] sector_bytes(input logic [2:0] code);
    sector_bytes = BASE_SECTOR_BYTES << code;
  endfunction

  logic [9:0]  cmd_q;
  logic [31:0] param_q;
  logic [15:0] gap_q;
  logic [15:0] cfg_q;
  logic [15:0] tim_q;
  logic [31:0] prdata_q;
  phase_e      ph_q;
  logic [7:0]  sec_q;
  logic        side_q;
  logic [14:0] idx_q;
  logic [7:0]  nsec_q;
  logic        match_q;
  logic        loaded_q;
  logic [3:0]  drv_q;

  logic        wr_en;
  logic        addr_hit;
  logic        start_wr;
  logic        soft_rst;
  logic        exec_end_wr;
  logic [2:0]  size_code;
  logic [7:0]  short_sector_length;
  logic [7:0]  last_sector_number;
  logic [14:0] phys_len;
  logic [14:0] xfer_len;
  logic        in_exec;
  logic        sector_end;
  logic        last_done;
  logic        wrap_side;
  logic        exec_fin;
  logic        settle_go;
  logic        settle_exp;
  logic        release_exp;
  logic        verify_count;

  // Address decode
  always_comb begin
    unique case (paddr)
      ADDR_CMD, ADDR_PARAM, ADDR_GAP, ADDR_CFG,
      ADDR_TIMING, ADDR_CTRL, ADDR_STATUS, ADDR_LENGTH: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  // APB handshake, zero wait states
  assign pready      = 1'b1;
  assign pslverr     = psel && penable && !addr_hit;
  assign wr_en       = psel && penable && pwrite && addr_hit;
  assign start_wr    = wr_en && (paddr == ADDR_CTRL) && pwdata[CTRL_START_BIT];
  assign soft_rst    = wr_en && (paddr == ADDR_CTRL) && pwdata[CTRL_SOFT_RST_BIT];
  assign exec_end_wr = wr_en && (paddr == ADDR_CTRL) && pwdata[CTRL_EXEC_END_BIT];

  // Command, parameter, gap and timing registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q   <= '0;
      param_q <= '0;
      gap_q   <= '0;
      tim_q   <= '0;
    end else if (wr_en) begin
      case (paddr)
        ADDR_CMD:    cmd_q   <= pwdata[9:0];
        ADDR_PARAM:  param_q <= pwdata;
        ADDR_GAP:    gap_q   <= pwdata[15:0];
        ADDR_TIMING: tim_q   <= pwdata[15:0];
        default:     ;
      endcase
    end
  end

  // Configuration with lock against soft reset; implied seek resets regardless
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= CFG_RST;
    end else if (wr_en && paddr == ADDR_CFG) begin
      cfg_q <= pwdata[15:0];
    end else if (soft_rst) begin
      cfg_q[IMPLIED_SEEK_BIT] <= CFG_RST[IMPLIED_SEEK_BIT];
      if (!cfg_q[LOCK_BIT]) begin
        cfg_q[BUFFER_DISABLE_N_BIT]             <= CFG_RST[BUFFER_DISABLE_N_BIT];
        cfg_q[THRESHOLD_LSB+:4]                 <= CFG_RST[THRESHOLD_LSB+:4];
        cfg_q[PRECOMP_LSB+:8]                   <= CFG_RST[PRECOMP_LSB+:8];
      end
    end
  end

  // Field extraction
  assign size_code           = param_q[SIZE_CODE_LSB+:3];
  assign short_sector_length = param_q[SHORT_LEN_LSB+:8];
  assign last_sector_number  = param_q[LAST_SECTOR_LSB+:8];
  assign verify_count        = cmd_q[VERIFY_CMD_BIT] && cmd_q[VERIFY_COUNT_MODE_BIT];

  always_comb begin
    phys_len = sector_bytes(size_code);
    xfer_len = phys_len;
    if (size_code == 3'h0 && !verify_count) begin
      xfer_len = {7'h00, short_sector_length};
    end
  end

  // Phase sequencer
  assign in_exec    = (ph_q == PH_EXEC);
  assign sector_end = in_exec && byte_tick && (idx_q == phys_len - 15'h0001);
  assign exec_fin   = in_exec && ((sector_end && last_done) || exec_end_wr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q <= PH_IDLE;
    end else if (soft_rst) begin
      ph_q <= PH_IDLE;
    end else begin
      unique case (ph_q)
        PH_IDLE: if (start_wr) begin
          ph_q <= (cfg_q[IMPLIED_SEEK_BIT] && cmd_q[HAS_CYLINDER_BIT]) ? PH_SEEK : PH_SETTLE;
        end
        PH_SEEK: if (seek_done) ph_q <= PH_SETTLE;
        PH_SETTLE: if (settle_exp) ph_q <= PH_EXEC;
        PH_EXEC: if (exec_fin) ph_q <= PH_RELEASE;
        PH_RELEASE: if (release_exp) ph_q <= PH_IDLE;
        // Unused state codes fall back to idle
        default: ph_q <= PH_IDLE;
      endcase
    end
  end

  // Settle timer starts as the phase enters settle
  assign settle_go = (ph_q == PH_IDLE && start_wr &&
                      !(cfg_q[IMPLIED_SEEK_BIT] && cmd_q[HAS_CYLINDER_BIT])) ||
                     (ph_q == PH_SEEK && seek_done);

  fcfd_delay #(.UNIT_CYCLES(HEAD_UNIT_CYCLES), .WIDTH(8)) u_settle (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (settle_go && !soft_rst),
    .units   (tim_q[SETTLE_LSB+:8]),
    .busy    (),
    .expired (settle_exp)
  );

  fcfd_delay #(.UNIT_CYCLES(HEAD_UNIT_CYCLES), .WIDTH(8)) u_release (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (exec_fin && !soft_rst),
    .units   (tim_q[RELEASE_LSB+:8]),
    .busy    (),
    .expired (release_exp)
  );

  // Head load level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loaded_q <= 1'b0;
    end else if (soft_rst || (ph_q == PH_RELEASE && release_exp)) begin
      loaded_q <= 1'b0;
    end else if (settle_go) begin
      loaded_q <= 1'b1;
    end
  end

  // Sector completion test
  always_comb begin
    wrap_side = (sec_q == last_sector_number) && cmd_q[CYLINDER_SPAN_BIT] && !side_q;
    if (verify_count) begin
      last_done = (nsec_q + 8'h01 == short_sector_length);
    end else begin
      last_done = (sec_q == last_sector_number) && !wrap_side;
    end
  end

  // Sector, side and byte index sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_q  <= '0;
      side_q <= 1'b0;
      idx_q  <= '0;
      nsec_q <= '0;
    end else if (ph_q == PH_IDLE && start_wr) begin
      sec_q  <= param_q[FIRST_SECTOR_LSB+:8];
      side_q <= cmd_q[CYLINDER_SPAN_BIT] ? 1'b0 : cmd_q[SIDE_SELECT_BIT];
      idx_q  <= '0;
      nsec_q <= '0;
    end else if (sector_end) begin
      idx_q  <= '0;
      nsec_q <= nsec_q + 8'h01;
      if (wrap_side) begin
        side_q <= 1'b1;
        sec_q  <= FIRST_SECTOR;
      end else begin
        sec_q <= sec_q + 8'h01;
      end
    end else if (in_exec && byte_tick) begin
      idx_q <= idx_q + 15'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_q <= 1'b0;
    end else if (id_valid) begin
      match_q <= (id_side == side_q);
    end
  end

  generate
    for (genvar i = 0; i < 4; i++) begin : g_drive
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          drv_q[i] <= 1'b0;
        end else begin
          drv_q[i] <= ({cmd_q[UNIT_SELECT_HI_BIT], cmd_q[UNIT_SELECT_LO_BIT]} == 2'(i));
        end
      end
    end
  endgenerate

  // Byte qualifiers
  // withhold extra read bytes
  assign host_byte_en = in_exec && byte_tick && (idx_q < xfer_len);
  assign zero_fill    = in_exec && (idx_q >= xfer_len);
  assign crc_byte_en  = in_exec && byte_tick;

  // Drive and format outputs
  // step direction
  assign step_in      = cmd_q[STEP_IN_BIT];
  assign seek_req     = (ph_q == PH_SEEK);
  assign head_load    = loaded_q;
  assign mfm_mode     = cmd_q[DENSITY_MFM_BIT];
  assign fifo_enable  = !cfg_q[BUFFER_DISABLE_N_BIT];
  assign buffer_threshold       = cfg_q[THRESHOLD_LSB+:4];
  assign precomp_start_cylinder = cfg_q[PRECOMP_LSB+:8];
  assign gap3_len     = gap_q[GAP3_LSB+:8];
  assign gap2_len     = cmd_q[PERPENDICULAR_BIT] ? gap_q[GAP2_LSB+:8] : GAP2_DEFAULT;
  assign drive_sel    = drv_q;
  assign side_out     = side_q;
  assign sector_num   = sec_q;
  assign id_side_match = match_q;
  assign exec_active  = in_exec;

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        ADDR_CMD:    prdata_q <= {22'h000000, cmd_q};
        ADDR_PARAM:  prdata_q <= param_q;
        ADDR_GAP:    prdata_q <= {16'h0000, gap_q};
        ADDR_CFG:    prdata_q <= {16'h0000, cfg_q};
        ADDR_TIMING: prdata_q <= {16'h0000, tim_q};
        ADDR_STATUS: prdata_q <= {8'h00, nsec_q, sec_q, 1'b0, ph_q,
                                  match_q, loaded_q, side_q, in_exec};
        ADDR_LENGTH: prdata_q <= {1'b0, xfer_len, 1'b0, phys_len};
        default:     prdata_q <= '0;
      endcase
    end
  end

  assign prdata = prdata_q;

  // Checks
  seek_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ADDR_CMD) |=> (step_in == $past(pwdata[STEP_IN_BIT])))
    else $error("step direction wrong");
  drive_dec_a: assert property (@(posedge pclk) disable iff (!presetn)
    $stable(cmd_q) |=> (drive_sel == (4'h1 << $past(cmd_q[1:0]))))
    else $error("drive decode wrong");
  short_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_exec && byte_tick && size_code == 3'h0 && !verify_count &&
     idx_q >= {7'h00, short_sector_length}) |-> !host_byte_en)
    else $error("extra byte passed");
  zero_tail_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_exec && byte_tick) |-> (host_byte_en != zero_fill))
    else $error("byte neither passed nor zero filled");
  crc_full_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_exec && byte_tick) |-> crc_byte_en)
    else $error("crc byte dropped");
  soft_default_a: assert property (@(posedge pclk) disable iff (!presetn)
    (soft_rst && !cfg_q[LOCK_BIT]) |=> !fifo_enable)
    else $error("buffer not disabled");
  lock_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (soft_rst && cfg_q[LOCK_BIT]) |=> $stable(cfg_q[15:4]) && $stable(fifo_enable))
    else $error("locked setting lost");
  implied_seek_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ph_q == PH_IDLE && start_wr && !soft_rst) |=>
      ((ph_q == PH_SEEK) == $past(cfg_q[IMPLIED_SEEK_BIT] && cmd_q[HAS_CYLINDER_BIT])))
    else $error("implied seek wrong");
  settle_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_exec && !$past(in_exec)) |-> $past(settle_exp) && head_load)
    else $error("exec before settle");
  span_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sector_end && wrap_side && !soft_rst) |=> side_q && sec_q == FIRST_SECTOR)
    else $error("span wrap wrong");
endmodule

// *** testbench/disk_engine_model.sv ***
/*
  Disk engine stand-in: paces byte ticks during execution, ends seeks and
  echoes sector identifiers. Assumes it shares pclk with the decoder.
*/
module disk_engine_model (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // From decoder
  input  wire logic seek_req,
  input  wire logic exec_active,
  input  wire logic side_out,
  // Fault control
  input  wire logic bad_side,
  // To decoder
  output logic      byte_tick,
  output logic      seek_done,
  output logic      id_valid,
  output logic      id_side
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [2:0] seek_cnt_q;
  logic       exec_q;
  logic       side_q;

  // One byte every other cycle, seek ends after five cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_tick  <= 1'b0;
      seek_done  <= 1'b0;
      seek_cnt_q <= 3'h0;
      exec_q     <= 1'b0;
      side_q     <= 1'b0;
      id_valid   <= 1'b0;
      id_side    <= 1'b0;
    end else begin
      byte_tick  <= exec_active & ~byte_tick;
      seek_cnt_q <= seek_req ? seek_cnt_q + 3'h1 : 3'h0;
      seek_done  <= seek_req && seek_cnt_q == 3'h4;
      exec_q     <= exec_active;
      side_q     <= side_out;
      id_valid   <= exec_active && (!exec_q || side_q != side_out);
      // Side field wiggles between identifiers so nothing stale reads true
      id_side    <= (exec_active && (!exec_q || side_q != side_out)) ?
                    side_out ^ bad_side : ~id_side;
    end
  end
endmodule

// *** testbench/floppy_command_field_decode_test.sv ***
/*
  Self-checking bench for the command field decoder over APB.
  Assumes the disk engine model on the same clock and four cycles per unit.
*/
module test_floppy_command_field_decode import fcfd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, bad_side = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, byte_tick, seek_done, id_valid, id_side, err;
  logic        side_out, step_in, seek_req, head_load, mfm_mode, fifo_enable;
  logic        host_byte_en, zero_fill, crc_byte_en, id_side_match, exec_active;
  logic [3:0]  drive_sel, buffer_threshold;
  logic [7:0]  precomp_start_cylinder, gap3_len, gap2_len, sector_num;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  int n_crc, n_host, n_zero, saw_seek, saw_s1;

  floppy_command_field_decode #(.HEAD_UNIT_CYCLES(4)) u_dut (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .byte_tick(byte_tick),
    .seek_done(seek_done), .id_valid(id_valid), .id_side(id_side), .drive_sel(drive_sel),
    .side_out(side_out), .step_in(step_in), .seek_req(seek_req), .head_load(head_load),
    .mfm_mode(mfm_mode), .fifo_enable(fifo_enable), .buffer_threshold(buffer_threshold),
    .precomp_start_cylinder(precomp_start_cylinder), .gap3_len(gap3_len),
    .gap2_len(gap2_len), .host_byte_en(host_byte_en), .zero_fill(zero_fill),
    .crc_byte_en(crc_byte_en), .sector_num(sector_num), .id_side_match(id_side_match),
    .exec_active(exec_active));

  disk_engine_model u_disk (.pclk(pclk), .presetn(presetn), .seek_req(seek_req),
    .exec_active(exec_active), .side_out(side_out), .bad_side(bad_side),
    .byte_tick(byte_tick), .seek_done(seek_done), .id_valid(id_valid), .id_side(id_side));

  // Clock and hang guard
  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      $display("[FAIL] %0t ns: run did not finish", $time);
      tally_and_finish;
    end
  end

  // Byte stream tallies and side one flag during execution, seek flag at any time
  always @(posedge pclk) begin
    n_crc += int'(crc_byte_en === 1'b1);
    n_host += int'(host_byte_en === 1'b1);
    n_zero += int'(zero_fill === 1'b1 && byte_tick === 1'b1 && exec_active === 1'b1);
    saw_seek |= int'(seek_req === 1'b1);
    saw_s1 |= int'(side_out === 1'b1 && exec_active === 1'b1);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic xfer(input logic [31:0] cmd, prm, cfg, input int crc, hst, zf,
                      input int sk, s1, input logic bad);
    int n;
    apb(1, ADDR_CFG, cfg);
    bad_side <= bad;
    apb(1, ADDR_CMD, cmd);
    apb(1, ADDR_PARAM, prm);
    {n_crc, n_host, n_zero, saw_seek, saw_s1} = '0;
    apb(1, ADDR_CTRL, 32'h1);
    n = 0;
    while (exec_active !== 1'b1) begin
      @(negedge pclk);
      n += int'(seek_req !== 1'b1);
    end
    chk(n >= 4 && n <= 9, 1);
    chk(sector_num, prm[31:24]);
    while (exec_active === 1'b1) @(negedge pclk);
    chk(id_side_match, !bad);
    n = 0;
    while (head_load === 1'b1) begin
      @(negedge pclk);
      n++;
    end
    chk(n >= 8 && n <= 12, 1);
    chk(n_crc, crc);
    chk(n_host, hst);
    chk(n_zero, zf);
    chk(saw_seek, sk);
    chk(saw_s1, s1);
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk(fifo_enable, 0);
    chk(gap2_len, 8'h16);
    apb(0, ADDR_CFG, 32'h0);
    chk(r, 32'h1);
    apb(0, 8'h20, 32'h0);
    chk({err, r}, {1'b1, 32'h0});
    for (int i = 0; i < 4; i++) begin
      apb(1, ADDR_CMD, 32'(i) | 32'(i & 1) << 3 | 32'(i >> 1) << 5);
      // Drive select is registered one cycle behind the command
      repeat (2) @(negedge pclk);
      chk(drive_sel, 32'h1 << i);
      chk(step_in, i & 1);
      chk(mfm_mode, i >> 1);
    end
    apb(1, ADDR_GAP, 32'h3327);
    apb(1, ADDR_CMD, 32'h200);
    @(negedge pclk);
    chk({gap2_len, gap3_len}, 16'h3327);
    apb(1, ADDR_CMD, 32'h0);
    @(negedge pclk);
    chk({gap2_len, gap3_len}, 16'h1627);
    apb(1, ADDR_CFG, 32'h5574);
    apb(1, ADDR_CTRL, 32'h2);
    @(negedge pclk);
    chk({fifo_enable, buffer_threshold, precomp_start_cylinder}, 13'h1755);
    apb(1, ADDR_CFG, 32'h5570);
    apb(1, ADDR_CTRL, 32'h2);
    @(negedge pclk);
    chk({fifo_enable, buffer_threshold, precomp_start_cylinder}, 13'h0);
    apb(1, ADDR_TIMING, 32'h0201);
    xfer(32'h100, 32'h01010400, 32'h2, 128, 4, 124, 1, 0, 0);
    xfer(32'h100, 32'h0101ff01, 32'h0, 256, 256, 0, 0, 0, 1);
    xfer(32'h0c0, 32'h01090200, 32'h0, 256, 256, 0, 0, 0, 0);
    xfer(32'h014, 32'h0101ff01, 32'h0, 512, 512, 0, 0, 1, 0);
    xfer(32'h000, 32'h0203ff01, 32'h0, 512, 512, 0, 0, 0, 1);
    tally_and_finish;
  end
endmodule
